/* hdl/fgml_defs.vh */
// Constants for the flight guidance mode logic: register map, fields,
// input pin positions and guidance figures.
// Assumes inclusion by bare name from the mode logic module and the guard monitor.
`ifndef FGML_DEFS_VH
`define FGML_DEFS_VH

// ==========================================================
// Register byte addresses
`define FGML_ADDR_CTRL 4'h0
`define FGML_ADDR_STATUS 4'h4
`define FGML_ADDR_MODE 4'h8
`define FGML_ADDR_HELD 4'hC
`define FGML_RESP_OKAY 2'h0
`define FGML_RESP_DECERR 2'h3

// ==========================================================
// Control register fields
`define FGML_CTRL_YD_REQ 0
`define FGML_CTRL_AP_REQ 1
`define FGML_CTRL_CRS_CHG 2

// ==========================================================
// Synchronised pin vector positions
`define FGML_PIN_W 24
`define FGML_P_DUMP 0
`define FGML_P_VG_OK 1
`define FGML_P_BIT_OK 2
`define FGML_P_GA 3
`define FGML_P_TRIM_OK 4
`define FGML_P_ETRIM 5
`define FGML_P_WHEEL 6
`define FGML_P_GDUMP 7
`define FGML_P_FD_BTN 8
`define FGML_P_HS_BTN 9
`define FGML_P_CRS_BTN 10
`define FGML_P_APR_BTN 11
`define FGML_P_CMP_OK 12
`define FGML_P_NAV_OK 13
`define FGML_P_RCV_OK 14
`define FGML_P_NAV_CAP 15
`define FGML_P_NAV_TRK 16
`define FGML_P_LAT_CAP 17
`define FGML_P_BANK4 18
`define FGML_P_BANK5 19
`define FGML_P_DEV3 20
`define FGML_P_LOC 21
`define FGML_P_ICPT90 22
`define FGML_P_GS_CAP 23

// ==========================================================
// Lateral states, one-hot
`define FGML_ST_W 7
`define FGML_ST_WL 7'h01
`define FGML_ST_HH 7'h02
`define FGML_ST_HS 7'h04
`define FGML_ST_CCAP 7'h08
`define FGML_ST_CTARM 7'h10
`define FGML_ST_CTRK 7'h20
`define FGML_ST_ACAP 7'h40

// ==========================================================
// Guidance figures
`define FGML_HDG_W 12
`define FGML_GA_PITCH_DEG 8'h0A
`endif

/* hdl/fgml_mode_logic.v */
// Flight guidance mode logic: engage permissions, lateral mode sequencing,
// go-around and pitch attitude hold, with an AXI4-Lite register slave.
// Assumes cockpit pins are asynchronous and a single 250 MHz clock.
`timescale 1ns/10ps
`include "fgml_defs.vh"

// Operation
// - Yaw damper permitted only without dump, with gyro valid and self test ok.
// - Autopilot permitted with yaw flag, no go-around, trim ok, trim off or steering.
// - Yaw damper and autopilot stay off while their permission is false.
// - Flight director on only while gyro valid and self test ok.
// - Excessive normal acceleration disengages the autopilot.
// - Reset: director, damper, autopilot off; damper and autopilot flags true.
// - A button counts again only after it was seen released.
// - Go-around or invalid compass holds lateral axis wings level.
// - With no selected mode revert to heading hold, latching compass heading.
// - Armed course or approach couples on its beam capture.
// - Heading select ends on second press or on course/approach coupling.
// - Course press with valid signal arms capture, lights arm lamp, keeps heading.
// - Track conditions or small bank and deviation couple course directly.
// - Capture to track-armed on bank over 5 degrees, then track on beam track.
// - Course capture cancels heading select and lights coupled lamp.
// - Course change while coupled falls back to course armed.
// - Course ends on second press or heading select or approach selection.
// - Approach press with valid receiver arms, lights lamp, keeps lateral mode unless course coupled.
// - Approach capture cancels heading mode and lights coupled lamp.
// - Tuned localizer intercept beyond 90 degrees sets reverse mode and inverts.
// - Reverse localizer blocks glideslope capture.
// - Go-around cancels modes, drops autopilot, wings level, 10 up, lamp.
module fgml_mode_logic (
  input wire aclk,                         // System clock
  input wire aresetn,                      // Synchronous reset, low
  input wire [`FGML_PIN_W-1:0] pins,       // Cockpit and sensor pins, asynchronous
  input wire [`FGML_HDG_W-1:0] compass_heading, // Compass heading, asynchronous
  input wire [3:0] s_axi_awaddr,           // Write address
  input wire s_axi_awvalid,                // Write address valid
  output reg s_axi_awready,                // Write address ready
  input wire [31:0] s_axi_wdata,           // Write data
  input wire [3:0] s_axi_wstrb,            // Write strobes
  input wire s_axi_wvalid,                 // Write data valid
  output reg s_axi_wready,                 // Write data ready
  output reg [1:0] s_axi_bresp,            // Write response
  output reg s_axi_bvalid,                 // Write response valid
  input wire s_axi_bready,                 // Write response ready
  input wire [3:0] s_axi_araddr,           // Read address
  input wire s_axi_arvalid,                // Read address valid
  output reg s_axi_arready,                // Read address ready
  output reg [31:0] s_axi_rdata,           // Read data
  output reg [1:0] s_axi_rresp,            // Read response
  output reg s_axi_rvalid,                 // Read data valid
  input wire s_axi_rready,                 // Read data ready
  output reg fd_on,                        // Flight director enabled
  output reg yd_on,                        // Yaw damper enabled
  output reg ap_on,                        // Autopilot enabled
  output reg [`FGML_ST_W-1:0] lat_state,   // Lateral state, one-hot
  output reg course_arm_lamp,              // Course armed lamp
  output reg course_coupled_lamp,          // Course coupled lamp
  output reg approach_arm_lamp,            // Approach armed lamp
  output reg approach_coupled_lamp,        // Approach coupled lamp
  output reg hdg_sel_lamp,                 // Heading select lamp
  output reg reverse_localizer,            // Reverse localizer lamp and inversion
  output reg go_around,                    // Go-around lamp and pitch mode
  output reg pitch_hold,                   // Pitch attitude hold active
  output reg [7:0] pitch_cmd_deg,          // Nose-up pitch command
  output reg glideslope_engaged,           // Glideslope captured
  output reg [`FGML_HDG_W-1:0] held_heading // Heading hold reference
);

  // ==========================================================
  // Input synchronisers
  reg [`FGML_PIN_W-1:0] pin_meta;
  reg [`FGML_PIN_W-1:0] pin_s;
  reg [`FGML_HDG_W-1:0] hdg_meta;
  reg [`FGML_HDG_W-1:0] hdg_s;
  reg [`FGML_PIN_W-1:0] pin_prev;
  reg yd_flag;
  reg ap_flag;
  reg fd_flag;
  reg [2:0] ctrl;
  reg crs_arm;
  reg apr_arm;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Two stages per bit; heading is assumed to move slowly against the clock
  always @(posedge aclk) begin
    pin_meta <= pins;
    pin_s <= pin_meta;
    hdg_meta <= compass_heading;
    hdg_s <= hdg_meta;
  end

  // ==========================================================
  // Button press detection
  wire [`FGML_PIN_W-1:0] press;
  // Previous starts high so a button held through reset gives no command
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= {`FGML_PIN_W{1'b1}};
    end else begin
      pin_prev <= pin_s;
    end
  end
  assign press = pin_s & ~pin_prev;

  wire ga_p = press[`FGML_P_GA];
  wire hs_p = press[`FGML_P_HS_BTN];
  wire crs_p = press[`FGML_P_CRS_BTN];
  wire apr_p = press[`FGML_P_APR_BTN];
  wire fd_p = press[`FGML_P_FD_BTN];
  wire crs_chg = ctrl[`FGML_CTRL_CRS_CHG];
  wire crs_cpl = lat_state[3] | lat_state[4] | lat_state[5];
  wire heading_mode = lat_state[1] | lat_state[2];

  // ==========================================================
  // Engage permissions and enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      yd_flag <= 1'b1;
      ap_flag <= 1'b1;
      fd_flag <= 1'b0;
      fd_on <= 1'b0;
      yd_on <= 1'b0;
      ap_on <= 1'b0;
    end else begin
      yd_flag <= ~pin_s[`FGML_P_DUMP] & pin_s[`FGML_P_VG_OK] & pin_s[`FGML_P_BIT_OK];
      ap_flag <= yd_flag & ~pin_s[`FGML_P_GA] & pin_s[`FGML_P_TRIM_OK]
        & (~pin_s[`FGML_P_ETRIM] | pin_s[`FGML_P_WHEEL]);
      fd_flag <= pin_s[`FGML_P_VG_OK] & pin_s[`FGML_P_BIT_OK];
      // Director toggles on its button, but only while permitted
      if (!fd_flag) begin
        fd_on <= 1'b0;
      end else if (fd_p) begin
        fd_on <= ~fd_on;
      end
      yd_on <= ctrl[`FGML_CTRL_YD_REQ] & yd_flag;
      // Director must already be on before the autopilot may engage
      ap_on <= ctrl[`FGML_CTRL_AP_REQ] & ap_flag & yd_flag & fd_on
        & ~pin_s[`FGML_P_GDUMP] & ~ga_p & ~go_around;
    end
  end

  // Disengage reasons clear the autopilot request so it stays off
  wire ap_drop = pin_s[`FGML_P_GDUMP] | ga_p | ~ap_flag;

  // ==========================================================
  // Lateral and pitch mode machine, one transition a clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      lat_state <= `FGML_ST_HH;
      crs_arm <= 1'b0;
      apr_arm <= 1'b0;
      go_around <= 1'b0;
      reverse_localizer <= 1'b0;
      glideslope_engaged <= 1'b0;
      held_heading <= {`FGML_HDG_W{1'b0}};
    end else if (ga_p) begin
      // Go-around outranks everything else this cycle
      go_around <= 1'b1;
      lat_state <= `FGML_ST_WL;
      crs_arm <= 1'b0;
      apr_arm <= 1'b0;
      reverse_localizer <= 1'b0;
      glideslope_engaged <= 1'b0;
    end else if (go_around && pin_s[`FGML_P_CMP_OK] && (hs_p || crs_p || apr_p)) begin
      // A lateral selection leaves go-around, but never without a valid compass
      go_around <= 1'b0;
      lat_state <= `FGML_ST_HH;
      held_heading <= hdg_s;
    end else if (go_around || !pin_s[`FGML_P_CMP_OK]) begin
      lat_state <= `FGML_ST_WL;
    end else if (lat_state[0]) begin
      lat_state <= `FGML_ST_HH;
      held_heading <= hdg_s;
    end else if (hs_p) begin
      if (lat_state[2]) begin
        lat_state <= `FGML_ST_HH;
        held_heading <= hdg_s;
      end else begin
        lat_state <= `FGML_ST_HS;
        crs_arm <= 1'b0;
        if (lat_state[6]) begin
          apr_arm <= 1'b0;
          reverse_localizer <= 1'b0;
          glideslope_engaged <= 1'b0;
        end
      end
    end else if (crs_p) begin
      if (crs_arm || crs_cpl) begin
        crs_arm <= 1'b0;
        if (crs_cpl) begin
          lat_state <= `FGML_ST_HH;
          held_heading <= hdg_s;
        end
      end else if (pin_s[`FGML_P_NAV_OK]) begin
        apr_arm <= 1'b0;
        if (pin_s[`FGML_P_NAV_TRK]
            || (pin_s[`FGML_P_BANK4] && pin_s[`FGML_P_DEV3])) begin
          lat_state <= `FGML_ST_CCAP;
        end else begin
          crs_arm <= 1'b1;
          if (!heading_mode) begin
            lat_state <= `FGML_ST_HH;
            held_heading <= hdg_s;
          end
        end
      end
    end else if (apr_p) begin
      if (apr_arm || lat_state[6]) begin
        apr_arm <= 1'b0;
        reverse_localizer <= 1'b0;
        glideslope_engaged <= 1'b0;
        if (lat_state[6]) begin
          lat_state <= `FGML_ST_HH;
          held_heading <= hdg_s;
        end
      end else if (pin_s[`FGML_P_RCV_OK]) begin
        apr_arm <= 1'b1;
        crs_arm <= 1'b0;
        if (crs_cpl) begin
          lat_state <= `FGML_ST_HH;
          held_heading <= hdg_s;
        end
      end
    end else if (crs_cpl && crs_chg) begin
      lat_state <= `FGML_ST_HH;
      held_heading <= hdg_s;
      crs_arm <= 1'b1;
    end else if (crs_arm && heading_mode && pin_s[`FGML_P_NAV_CAP]) begin
      lat_state <= `FGML_ST_CCAP;
      crs_arm <= 1'b0;
    end else if (apr_arm && heading_mode && pin_s[`FGML_P_LAT_CAP]) begin
      lat_state <= `FGML_ST_ACAP;
      apr_arm <= 1'b0;
      reverse_localizer <= pin_s[`FGML_P_LOC] & pin_s[`FGML_P_ICPT90];
    end else if (lat_state[3] && pin_s[`FGML_P_BANK5]) begin
      lat_state <= `FGML_ST_CTARM;
    end else if (lat_state[4] && pin_s[`FGML_P_NAV_TRK]) begin
      lat_state <= `FGML_ST_CTRK;
    end else if (lat_state[6] && !reverse_localizer && pin_s[`FGML_P_GS_CAP]) begin
      glideslope_engaged <= 1'b1;
    end
  end

  // ==========================================================
  // Annunciators and pitch command, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      course_arm_lamp <= 1'b0;
      course_coupled_lamp <= 1'b0;
      approach_arm_lamp <= 1'b0;
      approach_coupled_lamp <= 1'b0;
      hdg_sel_lamp <= 1'b0;
      pitch_hold <= 1'b1;
      pitch_cmd_deg <= 8'h00;
    end else begin
      course_arm_lamp <= crs_arm;
      course_coupled_lamp <= crs_cpl;
      approach_arm_lamp <= apr_arm;
      approach_coupled_lamp <= lat_state[6];
      hdg_sel_lamp <= lat_state[2];
      pitch_hold <= ~go_around;
      pitch_cmd_deg <= go_around ? `FGML_GA_PITCH_DEG : 8'h00;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel; address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FGML_RESP_OKAY;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      ctrl <= 3'h0;
    end else begin
      ctrl[`FGML_CTRL_CRS_CHG] <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `FGML_ADDR_CTRL) begin
          s_axi_bresp <= `FGML_RESP_OKAY;
          if (w_strb[0]) begin
            ctrl <= w_data[2:0];
          end
        end else if (aw_addr == `FGML_ADDR_STATUS || aw_addr == `FGML_ADDR_MODE
            || aw_addr == `FGML_ADDR_HELD) begin
          s_axi_bresp <= `FGML_RESP_OKAY; // Read-only, write ignored
        end else begin
          s_axi_bresp <= `FGML_RESP_DECERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // Safety: a disengage reason outranks a software request
      if (ap_drop) begin
        ctrl[`FGML_CTRL_AP_REQ] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FGML_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FGML_RESP_OKAY;
      case (s_axi_araddr)
        `FGML_ADDR_CTRL: s_axi_rdata <= {29'h00000000, ctrl};
        `FGML_ADDR_STATUS: s_axi_rdata <= {23'h000000, go_around, glideslope_engaged,
          reverse_localizer, fd_flag, ap_flag, yd_flag, ap_on, yd_on, fd_on};
        `FGML_ADDR_MODE: s_axi_rdata <= {23'h000000, apr_arm, crs_arm, 
          lat_state};
        `FGML_ADDR_HELD: s_axi_rdata <= {20'h00000, held_heading};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `FGML_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // fgml_mode_logic

/* bench/fgml_guard_monitor.sv */
// Checker for the flight guidance mode logic outputs against its pins.
// Assumes it is bound to fgml_mode_logic and sees only that module's ports.
`timescale 1ns/10ps
`include "fgml_defs.vh"
// ==========================================================
// Checker module
module fgml_guard (
  input wire aclk, // Clock
  input wire aresetn, // Reset, low
  input wire [`FGML_PIN_W-1:0] pins, // Cockpit pins
  input wire fd_on, // Director on
  input wire yd_on, // Yaw damper on
  input wire ap_on, // Autopilot on
  input wire [`FGML_ST_W-1:0] lat_state, // Lateral state
  input wire course_coupled_lamp, // Course coupled lamp
  input wire approach_coupled_lamp, // Approach coupled lamp
  input wire hdg_sel_lamp, // Heading select lamp
  input wire reverse_localizer, // Reverse localizer
  input wire go_around, // Go-around lamp
  input wire [7:0] pitch_cmd_deg, // Pitch command
  input wire glideslope_engaged // Glideslope engaged
);
  // Pins pass two synchroniser clocks, so levels are held six before judging
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_yd_dump: assert property (pins[`FGML_P_DUMP] [*6] |-> !yd_on)
    else $error("yaw damper on with dump pressed");
  a_ap_trim: assert property ((pins[5] && !pins[6]) [*6] |-> !ap_on)
    else $error("autopilot on with manual trim");
  a_fd_gyro: assert property (!pins[`FGML_P_VG_OK] [*6] |-> !fd_on)
    else $error("director on without gyro");
  a_ap_gdump: assert property (pins[`FGML_P_GDUMP] [*6] |-> !ap_on)
    else $error("autopilot on during g-dump");
  a_ap_ga: assert property (pins[`FGML_P_GA] [*6] |-> !ap_on)
    else $error("autopilot on during go-around");
  a_ga_pitch: assert property ($stable(go_around) |->
    pitch_cmd_deg == (go_around ? `FGML_GA_PITCH_DEG : 8'h00))
    else $error("pitch command wrong");
  a_ga_wings: assert property (go_around [*3] |-> lat_state == `FGML_ST_WL)
    else $error("not wings level in go-around");
  a_cmp_wings: assert property (!pins[`FGML_P_CMP_OK] [*6] |-> lat_state == `FGML_ST_WL)
    else $error("not wings level without compass");
  a_crs_lamp: assert property (((lat_state & 7'h38) != 7'h00) [*2] |-> course_coupled_lamp)
    else $error("course coupled lamp off");
  a_apr_lamp: assert property ((lat_state == `FGML_ST_ACAP) [*2] |->
    approach_coupled_lamp && !hdg_sel_lamp)
    else $error("approach capture lamps wrong");
  a_one_hot: assert property ($onehot(lat_state))
    else $error("lateral state not one-hot");
  a_rev_gs: assert property (reverse_localizer |-> !$rose(glideslope_engaged))
    else $error("glideslope captured in reverse");
endmodule // fgml_guard

/* bench/fgml_cockpit.sv */
// Cockpit model: steady sensor levels plus momentary buttons.
// Assumes the bench gives one-clock tap requests and steady conditions.
`timescale 1ns/10ps
// ==========================================================
// Cockpit model
module fgml_cockpit #(
  parameter HOLD = 8
) (
  input wire aclk, // Clock
  input wire [23:0] cond, // Steady sensor levels
  input wire [23:0] tap, // One-clock button request
  output reg [23:0] pins // Pin levels
);
  reg [23:0] btn = 24'h000000;
  integer left = 0;
  // A press stays down several clocks, like a pilot's finger
  always @(posedge aclk) begin
    if (tap != 24'h000000) begin
      btn <= tap;
      left <= HOLD;
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      btn <= 24'h000000;
    end
  end
  // Buttons ride on the sensor levels
  always @* pins = cond | btn;
endmodule // fgml_cockpit

/* bench/tb_top.sv */
// Self-checking bench for the flight guidance mode logic.
// Assumes the cockpit model drives the pins and the bench is the bus master.
`timescale 1ns/10ps
// ==========================================================
// Bench top
module tb_top;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [23:0] cond = 24'h007016;
  reg [23:0] tap = 24'h000000;
  wire [23:0] pins;
  reg [11:0] compass_heading = 12'h5A3;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 32'h00000000;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire fd_on, yd_on, ap_on, course_arm_lamp, course_coupled_lamp, approach_arm_lamp;
  wire approach_coupled_lamp, hdg_sel_lamp, reverse_localizer, go_around, pitch_hold;
  wire glideslope_engaged;
  wire [6:0] lat_state;
  wire [7:0] pitch_cmd_deg;
  wire [11:0] held_heading;
  integer bad_count = 0, num_checks = 0, i;
  // Row: conditions, button tap, lateral state, then lamp vector
  reg [63:0] rows [0:19] = '{
    64'h007016_000000_0500, 64'h007016_000200_0910, 64'h007016_000200_0500,
    64'h007016_000400_0501, 64'h00F016_000000_1102, 64'h08F016_000000_2102,
    64'h09F016_000000_4102, 64'h007016_000400_0500, 64'h007016_000800_0504,
    64'h027016_000000_8108, 64'h007016_000008_0280, 64'h007016_000200_0400,
    64'h006016_000000_0200, 64'h007016_000000_0400, 64'h007016_000800_0404,
    64'h627016_000000_8048, 64'hE27016_000000_8048, 64'h007016_000008_0280,
    64'h147016_000400_0400, 64'h147016_000400_1002};

  always #2 aclk = ~aclk;

  fgml_mode_logic i_dut (.*);
  fgml_cockpit #(.HOLD(8)) i_cockpit (.aclk(aclk), .cond(cond), .tap(tap), .pins(pins));

  // Compare and count
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Bus write, address and data offered together
  task axw(input [3:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // No local limit: only the watchdog ends a hung wait
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", s_axi_bresp, er);
    end
  endtask
  // Bus read, data taken at the edge rvalid is seen
  task axr(input [3:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", s_axi_rdata, ed);
      chk("rresp", s_axi_rresp, er);
    end
  endtask
  // New conditions and an optional tap, then let the pipeline settle
  task act(input [23:0] c, input [23:0] t);
    begin
      @(posedge aclk);
      cond <= c;
      tap <= t;
      @(posedge aclk);
      tap <= 24'h000000;
      repeat (14) @(posedge aclk);
      #1;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Watchdog, far beyond the expected run of under a thousand clocks
  initial begin
    repeat (6000) @(posedge aclk);
    bad_count = bad_count + 1;
    results;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    #1;
    chk("engage", {fd_on, yd_on, ap_on, pitch_hold}, 4'h1);
    chk("lat", lat_state, 7'h02);
    @(posedge aclk);
    aresetn <= 1'h1;
    axr(4'h4, 32'h00000038, 2'h0);
    act(24'h007016, 24'h000100);
    chk("fd_on", fd_on, 1'h1);
    axw(4'h0, 32'h00000003, 2'h0);
    act(24'h007016, 24'h000000);
    chk("yd_ap", {yd_on, ap_on}, 2'h3);
    act(24'h007036, 24'h000000);
    chk("ap_trim", ap_on, 1'h0);
    act(24'h007016, 24'h000000);
    axw(4'h0, 32'h00000003, 2'h0);
    act(24'h007096, 24'h000000);
    chk("ap_gdump", ap_on, 1'h0);
    act(24'h007016, 24'h000000);
    axw(4'h0, 32'h00000003, 2'h0);
    $display("engage test done");
    for (i = 0; i < 20; i = i + 1) begin
      act(rows[i][63:40], rows[i][39:16]);
      chk("lat", lat_state, rows[i][15:9]);
      chk("lamps", {ap_on, go_around, reverse_localizer, glideslope_engaged, hdg_sel_lamp,
        approach_coupled_lamp, approach_arm_lamp, course_coupled_lamp, course_arm_lamp},
        rows[i][8:0]);
    end
    $display("mode table done");
    // Course change while coupled drops back to armed
    axw(4'h0, 32'h00000004, 2'h0);
    act(24'h147016, 24'h000000);
    chk("crs_chg", {lat_state, course_arm_lamp, yd_on}, 9'h00A);
    axr(4'h8, 32'h00000082, 2'h0);
    axr(4'hC, 32'h000005A3, 2'h0);
    axr(4'h2, 32'h00000000, 2'h3);
    axw(4'h2, 32'h00000000, 2'h3);
    $display("course change and registers done");
    // Front-course approach: capture, then glideslope engages
    act(24'h007016, 24'h000800);
    axw(4'h0, 32'h00000001, 2'h0);
    act(24'h827016, 24'h000000);
    chk("apr_gs", {lat_state, glideslope_engaged, yd_on}, 9'h103);
    act(24'h007017, 24'h000000);
    chk("yd_dump", {yd_on, ap_on}, 2'h0);
    act(24'h007014, 24'h000000);
    chk("fd_gyro", fd_on, 1'h0);
    $display("monitor drop test done");
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    #1;
    chk("engage", {fd_on, yd_on, ap_on, pitch_hold}, 4'h1);
    chk("lat", lat_state, 7'h02);
    @(posedge aclk);
    aresetn <= 1'h1;
    act(24'h007016, 24'h000000);
    chk("lat", lat_state, 7'h02);
    $display("reset test done");
    results;
  end
endmodule // tb_top

bind fgml_mode_logic fgml_guard i_guard (.*);
